// *** verilog/fpe_cfg.svh ***
// Constants for the flash program/erase host controller.
// Assumes inclusion by bare name from the controller module.
`ifndef FPE_CFG_SVH
`define FPE_CFG_SVH
// Register offsets (byte addresses of 32-bit words).
`define FPE_REG_CTRL 12'h000
`define FPE_REG_ADDR 12'h004
`define FPE_REG_DATA 12'h008
`define FPE_REG_STAT 12'h00c
`define FPE_REG_RDAT 12'h010
// Control register fields: start pulse in bit 0, command in bits 6:4.
`define FPE_CTRL_GO 0
`define FPE_CMD_LSB 4
`define FPE_CMD_MSB 6
// Command codes.
`define FPE_CMD_PROG 3'h0
`define FPE_CMD_SERASE 3'h1
`define FPE_CMD_CERASE 3'h2
`define FPE_CMD_LOCK 3'h3
`define FPE_CMD_SUSP 3'h4
`define FPE_CMD_RESUME 3'h5
`define FPE_CMD_LOCKCHK 3'h6
`define FPE_CMD_READ 3'h7
// Unlock cycle addresses and data bytes.
`define FPE_UA1 19'h05555
`define FPE_UA2 19'h02aaa
`define FPE_UD1 8'haa
`define FPE_UD2 8'h55
`define FPE_D_PROG 8'ha0
`define FPE_D_ERS 8'h80
`define FPE_D_CERS 8'h10
`define FPE_D_SERS 8'h30
`define FPE_D_LOCK 8'h40
`define FPE_D_SUSP 8'hb0
`define FPE_D_IDENT 8'h90
`define FPE_D_EXIT 8'hf0
`define FPE_LOCK_OFS 19'h00002
// Bus timing in ns; each strobe phase lasts at least this long.
`define FPE_CLK_NS 40
`define FPE_PHASE_NS 100
`define FPE_PHASE_CYC ((`FPE_PHASE_NS + `FPE_CLK_NS - 1) / `FPE_CLK_NS)
// Power-up program inhibit time in us.
`define FPE_PWRUP_US 10000
`define FPE_PWRUP_CYC (`FPE_PWRUP_US * 1000 / `FPE_CLK_NS)
// Erase suspend latency in ns.
`define FPE_SUSP_NS 15000
`define FPE_SUSP_CYC ((`FPE_SUSP_NS + `FPE_CLK_NS - 1) / `FPE_CLK_NS)
`endif

// *** verilog/fpe_pkg.sv ***
// Types for the flash program/erase host controller.
// Assumes fpe_cfg.svh is available on the include path.
package fpe_pkg;
  typedef enum logic [6:0] {
    FPE_IDLE = 7'h01,
    FPE_WAIT = 7'h02,
    FPE_SETUP = 7'h04,
    FPE_STRB = 7'h08,
    FPE_HOLD = 7'h10,
    FPE_POLL = 7'h20,
    FPE_RDL = 7'h40
  } fpe_state_t;
endpackage

// *** verilog/fpe_host.sv ***
// Host controller that drives a parallel flash through its bus pins.
// Assumes an APB master on pclk and a flash whose pins are sampled here;
// the bidirectional data bus is resolved by the flash model from the enable.
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "fpe_cfg.svh"
module fpe_host
  import fpe_pkg::*;
#(
  parameter int PWRUP_CYC = `FPE_PWRUP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [18:0] fl_addr,
  output logic [15:0] fl_dq_o,
  output logic fl_dq_oe,
  input wire logic [15:0] fl_dq_i,
  output logic fl_ce_n,
  output logic fl_oe_n,
  output logic fl_we_n,
  input wire logic fl_ready_i,
  output logic fl_override
);
  // Register file and sequencer state.
  logic [2:0] cmd_ff;
  logic [18:0] addr_ff;
  logic [15:0] data_ff, rdat_ff, prev_ff;
  logic busy_ff, done_ff, locked_ff, susp_ff, ovr_ff, prev_vld_ff;
  logic [31:0] prdata_ff;
  fpe_state_t state_ff;
  logic [2:0] step_ff;
  logic [19:0] cnt_ff;
  logic [15:0] dq_s1_ff, dq_s2_ff;
  logic rdy_s1_ff, rdy_s2_ff;
  logic [18:0] fl_addr_ff;
  logic [15:0] fl_dq_ff;
  logic fl_oe_en_ff, fl_ce_ff, fl_oen_ff, fl_we_ff;

  // APB decode; the slave answers in the access cycle with no wait state.
  wire apb_wr = psel & penable & pwrite;
  wire apb_rd = psel & ~penable & ~pwrite;
  wire hit_ctrl = paddr == `FPE_REG_CTRL;
  wire hit_addr = paddr == `FPE_REG_ADDR;
  wire hit_data = paddr == `FPE_REG_DATA;
  wire hit_stat = paddr == `FPE_REG_STAT;
  wire hit_rdat = paddr == `FPE_REG_RDAT;
  wire mapped = hit_ctrl | hit_addr | hit_data | hit_stat | hit_rdat;
  wire [2:0] wr_cmd = pwdata[`FPE_CMD_MSB:`FPE_CMD_LSB];
  wire pwrup_done = cnt_ff == 20'(PWRUP_CYC);
  // Starting a new erase while one is suspended is refused here.
  wire is_erase = wr_cmd == `FPE_CMD_SERASE || wr_cmd == `FPE_CMD_CERASE;
  // Suspend may cut into an erase that is still being polled.
  wire susp_ok = state_ff == FPE_POLL && wr_cmd == `FPE_CMD_SUSP &&
                 (cmd_ff == `FPE_CMD_SERASE || cmd_ff == `FPE_CMD_CERASE);
  wire go = apb_wr & hit_ctrl & pwdata[`FPE_CTRL_GO] & (~busy_ff | susp_ok)
            & ~(susp_ff & is_erase);
  wire [31:0] stat_word = {26'h0, ovr_ff, susp_ff, locked_ff, rdy_s2_ff,
                           done_ff, busy_ff};
  wire [31:0] rd_mux = hit_ctrl ? {25'h0, cmd_ff, 4'h0} :
                       hit_addr ? {13'h0, addr_ff} :
                       hit_data ? {16'h0, data_ff} :
                       hit_stat ? stat_word :
                       hit_rdat ? {16'h0, rdat_ff} : 32'h0;

  // Number of write cycles per command; lock check adds exit.
  wire [2:0] ncyc = (cmd_ff == `FPE_CMD_PROG) ? 3'h4 :
                    (cmd_ff == `FPE_CMD_SUSP ||
                     cmd_ff == `FPE_CMD_RESUME) ? 3'h1 :
                    (cmd_ff == `FPE_CMD_LOCKCHK) ? 3'h3 :
                    (cmd_ff == `FPE_CMD_READ) ? 3'h0 : 3'h6;
  wire is_six = ncyc == 3'h6;
  wire [18:0] seq_a = (step_ff == 3'h1 || step_ff == 3'h4) ? `FPE_UA2 :
                      `FPE_UA1;
  wire [7:0] seq_d = (step_ff == 3'h1 || step_ff == 3'h4) ? `FPE_UD2 :
                     (step_ff == 3'h2 && is_six) ? `FPE_D_ERS :
                     (step_ff == 3'h2 && cmd_ff == `FPE_CMD_PROG) ?
                       `FPE_D_PROG :
                     (step_ff == 3'h2) ? `FPE_D_IDENT : `FPE_UD1;
  wire last = step_ff == ncyc - 3'h1;
  // Final cycle carries the target address and code, or the data word for program; chip erase and lock check use the first unlock address.
  wire [18:0] cyc_a = !last ? seq_a :
                      (cmd_ff == `FPE_CMD_CERASE) ? `FPE_UA1 :
                      (cmd_ff == `FPE_CMD_LOCKCHK) ? `FPE_UA1 : addr_ff;
  wire [7:0] last_d = (cmd_ff == `FPE_CMD_SERASE) ? `FPE_D_SERS :
                      (cmd_ff == `FPE_CMD_CERASE) ? `FPE_D_CERS :
                      (cmd_ff == `FPE_CMD_LOCK) ? `FPE_D_LOCK :
                      (cmd_ff == `FPE_CMD_SUSP) ? `FPE_D_SUSP :
                      (cmd_ff == `FPE_CMD_RESUME) ? `FPE_D_SERS :
                      `FPE_D_IDENT;
  wire [15:0] cyc_d = (last && cmd_ff == `FPE_CMD_PROG) ? data_ff :
                      {8'h0, last ? last_d : seq_d};
  wire phase_end = cnt_ff[7:0] == 8'(`FPE_PHASE_CYC);
  // Operation ends when two reads agree and busy is released.
  wire stable = prev_vld_ff && (prev_ff == dq_s2_ff) && rdy_s2_ff;
  wire poll_ok = dq_s2_ff[7] == data_ff[7];
  wire needs_poll = cmd_ff == `FPE_CMD_PROG || cmd_ff == `FPE_CMD_SERASE ||
                    cmd_ff == `FPE_CMD_CERASE || cmd_ff == `FPE_CMD_LOCK;

  // APB side registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_ff <= 3'h7;
      addr_ff <= 19'h0;
      data_ff <= 16'hffff;
      ovr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      if (go) cmd_ff <= wr_cmd;
      if (apb_wr & hit_addr) addr_ff <= pwdata[18:0];
      if (apb_wr & hit_data) data_ff <= pwdata[15:0];
      if (apb_wr & hit_stat) ovr_ff <= pwdata[5];
      if (apb_rd) prdata_ff <= rd_mux;
    end
  end

  // Two-flop synchronisers for the flash data bus and ready line.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_s1_ff <= 16'h0;
      dq_s2_ff <= 16'h0;
      rdy_s1_ff <= 1'b1;
      rdy_s2_ff <= 1'b1;
    end else begin
      dq_s1_ff <= fl_dq_i;
      dq_s2_ff <= dq_s1_ff;
      rdy_s1_ff <= fl_ready_i;
      rdy_s2_ff <= rdy_s1_ff;
    end
  end

  // Sequencer: waits out power-up, then issues writes and polls status.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= FPE_WAIT;
      step_ff <= 3'h0;
      cnt_ff <= 20'h0;
      busy_ff <= 1'b1;
      done_ff <= 1'b0;
      locked_ff <= 1'b0;
      susp_ff <= 1'b0;
      rdat_ff <= 16'h0;
      prev_ff <= 16'h0;
      prev_vld_ff <= 1'b0;
      fl_addr_ff <= 19'h0;
      fl_dq_ff <= 16'h0;
      fl_oe_en_ff <= 1'b0;
      fl_ce_ff <= 1'b1;
      fl_oen_ff <= 1'b1;
      fl_we_ff <= 1'b1;
    end else begin
      if (apb_wr & hit_stat & pwdata[1]) done_ff <= 1'b0;
      case (state_ff)
        FPE_WAIT: begin
          cnt_ff <= cnt_ff + 20'h1;
          if (pwrup_done) begin
            busy_ff <= 1'b0;
            state_ff <= FPE_IDLE;
          end
        end
        FPE_IDLE: begin
          step_ff <= 3'h0;
          cnt_ff <= 20'h0;
          prev_vld_ff <= 1'b0;
          if (go) begin
            busy_ff <= 1'b1;
            done_ff <= 1'b0;
            state_ff <= (wr_cmd == `FPE_CMD_READ) ? FPE_RDL : FPE_SETUP;
          end
        end
        FPE_SETUP: begin // Output enable high, drive address first.
          fl_oen_ff <= 1'b1;
          fl_addr_ff <= (cmd_ff == `FPE_CMD_LOCKCHK && step_ff == 3'h3) ?
                        `FPE_UA1 : cyc_a;
          fl_dq_ff <= (cmd_ff == `FPE_CMD_LOCKCHK && step_ff == 3'h3) ?
                      {8'h0, `FPE_D_EXIT} : cyc_d;
          fl_oe_en_ff <= 1'b1;
          fl_ce_ff <= 1'b0;
          cnt_ff <= 20'h0;
          state_ff <= FPE_STRB;
        end
        FPE_STRB: begin // Strobe low far longer than 15 ns.
          fl_we_ff <= 1'b0;
          cnt_ff <= cnt_ff + 20'h1;
          if (phase_end) begin
            fl_we_ff <= 1'b1;
            cnt_ff <= 20'h0;
            state_ff <= FPE_HOLD;
          end
        end
        FPE_HOLD: begin
          cnt_ff <= cnt_ff + 20'h1;
          if (phase_end) begin
            fl_ce_ff <= 1'b1;
            fl_oe_en_ff <= 1'b0;
            cnt_ff <= 20'h0;
            step_ff <= step_ff + 3'h1;
            if (cmd_ff == `FPE_CMD_LOCKCHK && step_ff == 3'h2)
              state_ff <= FPE_RDL; // Read lock word after entry.
            else if (cmd_ff == `FPE_CMD_LOCKCHK && step_ff == 3'h3) begin
              busy_ff <= 1'b0; // Exit written, back to array.
              done_ff <= 1'b1;
              state_ff <= FPE_IDLE;
            end else if (!last)
              state_ff <= FPE_SETUP;
            else if (cmd_ff == `FPE_CMD_SUSP || needs_poll)
              state_ff <= FPE_POLL; // Wait or poll.
            else begin
              susp_ff <= 1'b0; // Resume clears suspend.
              busy_ff <= 1'b0;
              done_ff <= 1'b1;
              state_ff <= FPE_IDLE;
            end
          end
        end
        FPE_POLL: begin // Repeated reads at the target address.
          fl_addr_ff <= addr_ff;
          fl_ce_ff <= 1'b0;
          fl_oen_ff <= 1'b0;
          cnt_ff <= cnt_ff + 20'h1;
          if (go) begin // Leave the erase poll to send suspend.
            step_ff <= 3'h0;
            state_ff <= FPE_SETUP;
          end else if (cmd_ff == `FPE_CMD_SUSP) begin
            if (cnt_ff == 20'(`FPE_SUSP_CYC)) begin
              susp_ff <= 1'b1;
              busy_ff <= 1'b0;
              done_ff <= 1'b1;
              fl_ce_ff <= 1'b1;
              fl_oen_ff <= 1'b1;
              state_ff <= FPE_IDLE;
            end
          end else if (phase_end) begin
            cnt_ff <= 20'h0;
            fl_oen_ff <= 1'b1;
            prev_ff <= dq_s2_ff;
            prev_vld_ff <= 1'b1;
            if (stable && (cmd_ff != `FPE_CMD_PROG || poll_ok)) begin
              rdat_ff <= dq_s2_ff;
              busy_ff <= 1'b0;
              done_ff <= 1'b1;
              fl_ce_ff <= 1'b1;
              state_ff <= FPE_IDLE;
            end
          end
        end
        FPE_RDL: begin // Plain read, or lock word read.
          fl_addr_ff <= (cmd_ff == `FPE_CMD_LOCKCHK) ?
                        (addr_ff | `FPE_LOCK_OFS) : addr_ff;
          fl_ce_ff <= 1'b0;
          fl_oen_ff <= 1'b0;
          cnt_ff <= cnt_ff + 20'h1;
          if (phase_end) begin
            cnt_ff <= 20'h0;
            rdat_ff <= dq_s2_ff;
            fl_oen_ff <= 1'b1;
            fl_ce_ff <= 1'b1;
            if (cmd_ff == `FPE_CMD_LOCKCHK) begin
              locked_ff <= dq_s2_ff[0];
              state_ff <= FPE_SETUP;
            end else begin
              busy_ff <= 1'b0;
              done_ff <= 1'b1;
              state_ff <= FPE_IDLE;
            end
          end
        end
        default: state_ff <= FPE_IDLE;
      endcase
    end
  end

  // Outputs come straight from flops, with pready and pslverr tied off; APB never stalls.
  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign fl_addr = fl_addr_ff;
  assign fl_dq_o = fl_dq_ff;
  assign fl_dq_oe = fl_oe_en_ff;
  assign fl_ce_n = fl_ce_ff;
  assign fl_oe_n = fl_oen_ff;
  assign fl_we_n = fl_we_ff;
  assign fl_override = ovr_ff;

  // Write strobe low only with output enable high and chip select low.
  a_write_inhibit: assert property (@(posedge pclk) disable iff (!presetn)
    !fl_we_ff |-> fl_oen_ff && !fl_ce_ff)
    else $error("write strobe low with output enable or select wrong");
  // Strobe pulse lasts several cycles, far above the noise filter.
  a_strobe_width: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(fl_we_ff) |-> !fl_we_ff [*3])
    else $error("write strobe pulse too short");
  // No flash write during the power-up wait.
  a_pwrup_block: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == FPE_WAIT |-> fl_we_ff && fl_ce_ff)
    else $error("flash touched during power-up wait");
  // Data is driven throughout the strobe.
  a_data_driven: assert property (@(posedge pclk) disable iff (!presetn)
    !fl_we_ff |-> fl_oe_en_ff && $stable(fl_dq_ff))
    else $error("data not held while strobe low");
  // The last program cycle carries the caller's word, not a command code.
  a_prog_data: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(fl_we_ff) && cmd_ff == `FPE_CMD_PROG && step_ff == 3'h3
    |-> fl_dq_ff == data_ff)
    else $error("program cycle lost its data word");
endmodule

// *** sim/fpe_flash_model.sv ***
// Behavioural parallel flash seen by the host controller under test.
// Assumes strobes come from the host flops; resolves the shared data wire
// and the pulled-up ready/busy line itself.
`timescale 1ns/1ps
module fpe_flash_model #(
  parameter int PROG_NS = 2000,
  parameter int ERS_NS = 40000,
  parameter int PWRUP_NS = 500
) (
  input wire logic [18:0] a,
  input wire logic [15:0] d,
  input wire logic oe_h,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic hv,
  output logic [15:0] q,
  output logic rdy
);
  logic [15:0] mem [logic [18:0]];
  bit lk [logic [6:0]];
  int st = 0;
  int left = 0;
  logic pbusy = 0, ebusy = 0, susp = 0, ident = 0, tg = 0, tg2 = 0;
  logic ech = 0, bpl = 0;
  logic [6:0] es = 0;
  logic [6:0] s;
  logic [18:0] la = 0;
  logic [15:0] ld = 0, lq = 0;
  realtime tf = -100.0;
  wire pl = (a[18:16] != 3'h0);
  function automatic logic [15:0] rd(input logic [18:0] x);
    return mem.exists(x) ? mem[x] : 16'hffff;
  endfunction
  // A released wire shows the inverse of its last value, not a kind guess.
  assign q = (!ce_n && !oe_n && we_n) ? lq : oe_h ? d : ~lq;
  assign rdy = !(pbusy || ebusy);
  always @(negedge we_n) tf = $realtime;
  // Commands are taken at the rising write strobe under chip select.
  always @(posedge we_n) begin
    if (!ce_n && oe_n && $realtime - tf >= 15.0) begin
      if (pbusy) begin
        st = 0;
      end else if (ebusy) begin
        if (d[7:0] == 8'hb0) begin
          ebusy = 0;
          susp = 1;
        end
      end else if (st == 0) begin
        if (a == 19'h05555 && d[7:0] == 8'haa) st = 1;
        else if (susp && d[7:0] == 8'h30 && pl == bpl) begin
          susp = 0;
          ebusy = 1;
        end else if (d[7:0] == 8'hf0) ident = 0;
      end else if (st == 1) begin
        st = (a == 19'h02aaa && d[7:0] == 8'h55) ? 2 : 0;
      end else if (st == 2) begin
        st = (d[7:0] == 8'ha0) ? 3 : (d[7:0] == 8'h80) ? 4 : 0;
        if (d[7:0] == 8'h90) ident = 1;
        if (d[7:0] == 8'hf0) ident = 0;
      end else if (st == 3) begin
        st = 0;
        if ($realtime >= PWRUP_NS && (hv || !lk.exists(a[18:12]))) begin
          la = a;
          ld = d;
          bpl = pl;
          pbusy = 1;
          fork
            begin
              #(PROG_NS);
              mem[la] = rd(la) & ld;
              pbusy = 0;
            end
          join_none
        end
      end else if (st == 4) st = (d[7:0] == 8'haa) ? 5 : 0;
      else if (st == 5) st = (d[7:0] == 8'h55) ? 6 : 0;
      else begin
        st = 0;
        s = a[18:12];
        if (d[7:0] == 8'h40) lk[s] = 1;
        else if (!susp && (d[7:0] == 8'h10 || (d[7:0] == 8'h30 &&
                 (hv || !lk.exists(s))))) begin
          ech = (d[7:0] == 8'h10);
          es = s;
          bpl = pl;
          left = ERS_NS / 40;
          ebusy = 1;
        end
      end
    end
  end
  // Erase runs down in 40 ns steps so a suspend keeps what is left.
  initial forever begin
    #40;
    if (ebusy && left > 0) left--;
    else if (ebusy) begin
      foreach (mem[k])
        if ((ech || k[18:12] == es) && (hv || !lk.exists(k[18:12])))
          mem[k] = 16'hffff;
      ebusy = 0;
    end
  end
  // Toggle bits replace array data only in the busy plane, and bit 2 in the suspended sector.
  // Address and select move on the same edge, so let them settle first.
  always @(negedge oe_n) begin
    #1;
    if (!ce_n && ident && a[11:0] == 12'h002) begin
      lq = {15'h0, lk.exists(a[18:12])};
    end else if (!ce_n) begin
      lq = rd(a);
      if ((pbusy || ebusy) && pl == bpl) begin
        tg = ~tg;
        lq[6] = tg;
        lq[7] = pbusy ? ((a == la) ? ~ld[7] : lq[7]) : 1'b0;
      end
      if (susp && a[18:12] == es) begin
        tg2 = ~tg2;
        lq[2] = tg2;
      end
    end
  end
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench: APB tasks drive the host, a flash model answers.
// Assumes the flash model file is compiled before this one.
`timescale 1ns/1ps
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q, q1;
  logic pready, pslverr, fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, fl_override;
  logic [18:0] fl_addr;
  logic [15:0] fl_dq_o, fl_dq_i;
  logic fl_ready_i;
  int err_count = 0, cmp_count = 0, cyc = 0;
  fpe_host #(.PWRUP_CYC(20)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe),
    .fl_dq_i(fl_dq_i), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n), .fl_ready_i(fl_ready_i), .fl_override(fl_override));
  fpe_flash_model u_flash (.a(fl_addr), .d(fl_dq_o), .oe_h(fl_dq_oe),
    .ce_n(fl_ce_n), .oe_n(fl_oe_n), .we_n(fl_we_n), .hv(fl_override),
    .q(fl_dq_i), .rdy(fl_ready_i));
  initial forever #20 pclk = ~pclk;
  task close_out;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // The ceiling is about forty times the longest erase plus polling.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      close_out;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  // Issue one command and wait for busy to fall; reads its status first.
  task run(input logic [2:0] c, input logic [18:0] a, input logic [15:0] d);
    apb(1, `FPE_REG_ADDR, {13'h0, a});
    apb(1, `FPE_REG_DATA, {16'h0, d});
    apb(1, `FPE_REG_CTRL, {25'h0, c, 4'h1});
    apb(0, `FPE_REG_STAT, 32'h0);
    chk({31'h0, q[0]}, 32'h1);
    do apb(0, `FPE_REG_STAT, 32'h0); while (q[0] !== 1'b0);
  endtask
  task rdw(input logic [18:0] a, input logic [15:0] exp);
    run(`FPE_CMD_READ, a, 16'h0);
    apb(0, `FPE_REG_RDAT, 32'h0);
    chk(q, {16'h0, exp});
  endtask
  task lockchk(input logic [18:0] a, input logic exp);
    run(`FPE_CMD_LOCKCHK, a, 16'h0);
    apb(0, `FPE_REG_STAT, 32'h0);
    chk({31'h0, q[3]}, {31'h0, exp});
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    apb(0, `FPE_REG_STAT, 32'h0);
    chk({31'h0, q[0]}, 32'h1);
    do apb(0, `FPE_REG_STAT, 32'h0); while (q[0] !== 1'b0);
    chk({31'h0, q[2]}, 32'h1);
    apb(0, 12'h020, 32'h0);
    chk(q, 32'h0);
    run(`FPE_CMD_PROG, 19'h005a5, 16'h00ff);
    rdw(19'h005a5, 16'h00ff);
    run(`FPE_CMD_PROG, 19'h005a5, 16'hf0f0);
    rdw(19'h005a5, 16'h00f0);
    run(`FPE_CMD_SERASE, 19'h005a5, 16'h0);
    rdw(19'h005a5, 16'hffff);
    run(`FPE_CMD_LOCK, 19'h09000, 16'h0);
    lockchk(19'h09000, 1'b1);
    lockchk(19'h0a000, 1'b0);
    rdw(19'h09000, 16'hffff);
    run(`FPE_CMD_PROG, 19'h09010, 16'h12b4);
    rdw(19'h09010, 16'hffff);
    run(`FPE_CMD_PROG, 19'h0a010, 16'h12b4);
    rdw(19'h0a010, 16'h12b4);
    apb(1, `FPE_REG_STAT, 32'h20);
    @(posedge pclk);
    chk({31'h0, fl_override}, 32'h1);
    run(`FPE_CMD_PROG, 19'h09010, 16'h12b4);
    rdw(19'h09010, 16'h12b4);
    apb(1, `FPE_REG_STAT, 32'h0);
    run(`FPE_CMD_SERASE, 19'h09010, 16'h0);
    rdw(19'h09010, 16'h12b4);
    run(`FPE_CMD_CERASE, 19'h0, 16'h0);
    rdw(19'h0a010, 16'hffff);
    rdw(19'h09010, 16'h12b4);
    // Erase a sector, suspend it once the flash reports busy, then resume.
    run(`FPE_CMD_PROG, 19'h0b010, 16'h12b4);
    apb(1, `FPE_REG_ADDR, 32'h0000b000);
    apb(1, `FPE_REG_CTRL, {25'h0, `FPE_CMD_SERASE, 4'h1});
    do apb(0, `FPE_REG_STAT, 32'h0); while (q[2] !== 1'b0);
    apb(1, `FPE_REG_CTRL, {25'h0, `FPE_CMD_SUSP, 4'h1});
    do apb(0, `FPE_REG_STAT, 32'h0); while (q[0] !== 1'b0);
    chk({31'h0, q[4]}, 32'h1);
    run(`FPE_CMD_READ, 19'h0b010, 16'h0);
    apb(0, `FPE_REG_RDAT, 32'h0);
    q1 = q;
    run(`FPE_CMD_READ, 19'h0b010, 16'h0);
    apb(0, `FPE_REG_RDAT, 32'h0);
    chk(q1 ^ q, 32'h4);
    run(`FPE_CMD_PROG, 19'h0c010, 16'h5a5a);
    rdw(19'h0c010, 16'h5a5a);
    apb(1, `FPE_REG_CTRL, {25'h0, `FPE_CMD_SERASE, 4'h1});
    apb(0, `FPE_REG_STAT, 32'h0);
    chk({30'h0, q[4], q[0]}, 32'h2);
    run(`FPE_CMD_RESUME, 19'h00000, 16'h0);
    chk({31'h0, q[4]}, 32'h0);
    do apb(0, `FPE_REG_STAT, 32'h0); while (q[2] !== 1'b1);
    rdw(19'h0b010, 16'hffff);
    rdw(19'h0c010, 16'h5a5a);
    close_out;
  end
endmodule
